// ---- dv/dit_master_model.sv ----
// controlling station model: one frame, then one reply slot
// assumes replies are registered one cycle after the frame edge
`timescale 1ns/1ps
module dit_master_model (
  // clock
  input wire logic pclk,
  // link
  output dit_pkg::dit_rx_t rx,
  input wire dit_pkg::dit_tx_t tx,
  // replies seen outside a slot
  output int stray
);
  import dit_pkg::*;
  int cnt = 0;
  logic sent = 1'b0;
  assign stray = cnt;
  initial rx = '0;
  // frames only start here, the slave never speaks first
  task automatic xfer(input dit_rx_t f, output logic got, output dit_tx_t r);
    dit_rx_t idle;
    f.valid = 1'b1;
    idle = ~f;
    idle.valid = 1'b0;
    @(posedge pclk);
    rx <= f;
    @(posedge pclk);
    rx <= idle;
    #1;
    got = tx.valid;
    r = tx;
  endtask
  // count replies not preceded by a frame
  always @(posedge pclk) begin
    if (tx.valid === 1'b1 && sent !== 1'b1) cnt <= cnt + 1;
    sent <= rx.valid;
  end
endmodule

// ---- dv/dit_slave_checker.sv ----
// port assertions for the telecontrol slave
// assumes a bind onto dit_slave, one clock pclk, async reset presetn
`timescale 1ns/1ps
module dit_slave_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // link
  input wire dit_pkg::dit_rx_t rx,
  input wire dit_pkg::dit_tx_t tx
);
  import dit_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // replies only in the slot after a frame
  AST_NO_UNPROMPTED: assert property (tx.valid |-> $past(rx.valid))
    else $error("reply without a request");
  AST_RESET_ACK: assert property (tx.valid && ($past(rx.fc) == DIT_FC_RST_CU || $past(rx.fc) == DIT_FC_RST_FCB)
    |-> tx.kind == DIT_RPL_ACK) else $error("link reset not acknowledged");
  AST_SYNC_ACK: assert property (tx.valid && $past(rx.fc) == DIT_FC_UDATA && $past(rx.ti) == DIT_TI_SYNC
    && $past(rx.cot) == DIT_COT_SYNC |-> tx.kind == DIT_RPL_ACK) else $error("sync not acknowledged");
  AST_BCAST_SILENT: assert property (rx.valid && rx.addr == DIT_BCAST |=> !tx.valid)
    else $error("reply to broadcast");
  AST_GI_ACK: assert property (tx.valid && $past(rx.fc) == DIT_FC_UDATA && $past(rx.ti) == DIT_TI_GI
    && $past(rx.cot) == DIT_COT_GI |-> tx.kind == DIT_RPL_ACK) else $error("interrogation not acknowledged");
  AST_GI_END: assert property (tx.valid && tx.cot == DIT_COT_GI_END
    |-> tx.ti == DIT_TI_GI_END && tx.fun == DIT_FUN_GLOBAL) else $error("bad end of interrogation");
  AST_SPONT: assert property (tx.valid && tx.cot == DIT_COT_SPONT
    |-> tx.ti == DIT_TI_DPI && tx.kind == DIT_RPL_ASDU) else $error("bad spontaneous message");
  AST_PAIR_REFUSE: assert property (psel && penable && pwrite && paddr == DIT_OFS_PAIR
    && (pwdata & ~{16'h0000, DIT_PAIR_OK}) != 32'h0000_0000 |-> pslverr) else $error("bad pairing taken");
endmodule
bind dit_slave dit_slave_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .rx(rx), .tx(tx));

// ---- dv/dit_slave_tb_top.sv ----
// self-checking bench of the telecontrol slave
// assumes dit_pkg, dit_slave, the master model and the bound checker
`timescale 1ns/1ps
module dit_slave_tb_top;
  import dit_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, got;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic [15:0] in_raw;
  dit_rx_t rx;
  dit_tx_t tx, r;
  dit_time_t now_tm;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int stray, p, g, i;
  int exp_inf[$];
  dit_slave #(.TICK_CYC(10), .QDEPTH(DIT_QDEPTH)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_raw(in_raw), .rx(rx), .tx(tx));
  dit_master_model mm (.pclk(pclk), .rx(rx), .tx(tx), .stray(stray));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // verdict
  task automatic close_out();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp_val(input logic [39:0] a, input logic [39:0] e);
    samples_checked++;
    if (a !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic rpl_is(input logic [1:0] k, input logic [7:0] ti, cot, fun, inf);
    cmp_val(40'({got, r.kind, r.ti, r.cot, r.fun, r.inf}), 40'({1'b1, k, ti, cot, fun, inf}));
  endtask
  // apb master: setup, then access until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] a, input logic [3:0] fc, input logic [7:0] ti, cot);
    dit_rx_t f;
    f = '0;
    f.addr = a;
    f.fc = fc;
    f.ti = ti;
    f.cot = cot;
    f.tm = now_tm; // full time structure in every frame
    mm.xfer(f, got, r);
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    in_raw = 16'h0000;
    now_tm = '0;
    lfsr = 32'h0000_1274;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DIT_OFS_CTRL, 32'h0000_0000);
    cmp_val(40'(rd), 40'({8'h00, DIT_RST_FUN, 8'h00, DIT_RST_ADDR}));
    apb(1'b0, 8'h30, 32'h0000_0000);
    cmp_val(40'({err, rd}), 40'({1'b1, 32'h0000_0000}));
    apb(1'b1, DIT_OFS_FILT, 32'h0000_0003);
    send(8'h01, DIT_FC_CLASS2, 8'h00, 8'h00);
    cmp_val(40'(got), 40'(1'b0));
    send(8'h02, DIT_FC_RST_CU, 8'h00, 8'h00);
    cmp_val(40'(got), 40'(1'b0));
    send(8'h01, DIT_FC_RST_FCB, 8'h00, 8'h00); // opening reset
    cmp_val(40'({got, r.kind, r.acd, r.addr}), 40'({1'b1, DIT_RPL_ACK, 1'b1, DIT_RST_ADDR}));
    now_tm = {8'h0C, 8'h22, 16'h1388};
    send(8'h01, DIT_FC_UDATA, DIT_TI_SYNC, DIT_COT_SYNC);
    cmp_val(40'({got, r.kind}), 40'({1'b1, DIT_RPL_ACK}));
    now_tm = {8'h05, 8'h11, 16'h0000};
    send(DIT_BCAST, DIT_FC_UDATA, DIT_TI_SYNC, DIT_COT_SYNC);
    cmp_val(40'(got), 40'(1'b0));
    lfsr = lfsr_next(lfsr);
    g = 3 + int'(lfsr % 14);
    lfsr = lfsr_next(lfsr);
    p = 3 + int'(lfsr % 14);
    @(posedge pclk);
    in_raw[g-1] <= 1'b1;
    repeat (15) @(posedge pclk);
    in_raw[g-1] <= 1'b0;
    repeat (60) @(posedge pclk);
    in_raw[p-1] <= 1'b1;
    repeat (60) @(posedge pclk);
    send(8'h01, DIT_FC_CLASS2, 8'h00, 8'h00);
    cmp_val(40'({got, r.kind, r.acd}), 40'({1'b1, DIT_RPL_NODATA, 1'b1}));
    send(8'h01, DIT_FC_CLASS1, 8'h00, 8'h00);
    rpl_is(DIT_RPL_ASDU, DIT_TI_DPI, DIT_COT_SPONT, DIT_RST_FUN, 8'(p));
    cmp_val(40'({r.dpi, r.tm.hour, r.tm.min}), 40'({2'b10, 8'h05, 8'h11}));
    send(8'h01, DIT_FC_CLASS1, 8'h00, 8'h00);
    rpl_is(DIT_RPL_ASDU, DIT_TI_IDENT, DIT_COT_START, DIT_FUN_GLOBAL, DIT_INF_IDENT);
    cmp_val(40'(r.acd), 40'(1'b0));
    apb(1'b1, DIT_OFS_PAIR, 32'h0000_0002);
    cmp_val(40'(err), 40'(1'b1));
    apb(1'b1, DIT_OFS_PAIR, 32'h0000_0001);
    apb(1'b0, DIT_OFS_PAIR, 32'h0000_0000);
    cmp_val(40'({err, rd}), 40'({1'b0, 32'h0000_0001}));
    apb(1'b0, 8'h44, 32'h0000_0000);
    cmp_val(40'({err, rd}), 40'({1'b1, 32'h0000_0000}));
    apb(1'b0, DIT_OFS_STAT, 32'h0000_0000);
    cmp_val(40'(rd[15:8]), 40'(8'h0F));
    for (i = 1; i <= 16; i++) if (i != 2) exp_inf.push_back(i);
    send(8'h01, DIT_FC_UDATA, DIT_TI_GI, DIT_COT_GI);
    cmp_val(40'({got, r.kind}), 40'({1'b1, DIT_RPL_ACK}));
    for (i = 0; i < 20; i++) begin
      send(8'h01, DIT_FC_CLASS2, 8'h00, 8'h00); // keep polling until the end message
      if (r.cot === DIT_COT_GI_END || exp_inf.size() == 0) break;
      g = exp_inf.pop_front();
      rpl_is(DIT_RPL_ASDU, DIT_TI_DPI, DIT_COT_GI, DIT_RST_FUN, 8'(g));
      cmp_val(40'(r.dpi), 40'((g == 1) ? 2'b00 : ((g == p) ? 2'b10 : 2'b01)));
    end
    rpl_is(DIT_RPL_ASDU, DIT_TI_GI_END, DIT_COT_GI_END, DIT_FUN_GLOBAL, 8'h00);
    cmp_val(40'(exp_inf.size()), 40'(0));
    apb(1'b1, DIT_OFS_CTRL, {8'h00, DIT_RST_FUN, 8'h01, DIT_RST_ADDR});
    repeat (60) @(posedge pclk);
    apb(1'b0, DIT_OFS_INP, 32'h0000_0000);
    cmp_val(40'(rd[15:0]), 40'(16'(~in_raw)));
    cmp_val(40'(stray), 40'(0));
    close_out();
  end
endmodule

// ---- hdl/dit_evt_queue.sv ----
// first-in first-out queue of spontaneous change records
// assumes a single clock; push and pop may happen in one cycle
`timescale 1ns/1ps
module dit_evt_queue #(
  parameter int unsigned W = 38,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [W-1:0] push_data,
  // drain side
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [W-1:0] pop_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic do_push;
  logic do_pop;

  // honest full and empty from the fill count
  assign push_ready = (count != (AW+1)'(DEPTH));
  assign pop_valid = (count != '0);
  assign pop_data = mem[rd_reg];
  assign do_push = push_valid && push_ready;
  assign do_pop = pop_valid && pop_ready;

  // storage
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_reg] <= push_data;
    end
  end

  // pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// ---- hdl/dit_glitch_filter.sv ----
// per-input glitch filter counting millisecond ticks
// assumes inputs synchronous to pclk and a one-cycle tick enable
`timescale 1ns/1ps
module dit_glitch_filter #(
  parameter int unsigned N = 16,
  parameter int unsigned CW = 18
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic [CW-1:0] limit,
  // inputs and results
  input wire logic [N-1:0] din,
  output logic [N-1:0] stable,
  output logic [N-1:0] chg
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic [CW-1:0] cnt_reg;
      logic done;
      assign done = (limit == '0) || (tick && (cnt_reg + 1'b1 >= limit));
      // count while the input differs, accept after a full quiet time
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= '0;
          stable[g] <= 1'b0;
          chg[g] <= 1'b0;
        end else begin
          chg[g] <= 1'b0;
          if (din[g] == stable[g]) begin
            cnt_reg <= '0; // glitch shorter than limit dropped
          end else if (done) begin
            cnt_reg <= '0;
            stable[g] <= din[g];
            chg[g] <= 1'b1;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule

// ---- hdl/dit_pkg.sv ----
// constants, records and states of the digital input telecontrol slave
// assumes a 25 MHz system clock and a frame codec outside the block
package dit_pkg;
  // clock and time base
  localparam int unsigned DIT_CLK_HZ = 25_000_000;
  localparam int unsigned DIT_TICK_US = 1000;
  localparam int unsigned DIT_TICK_CYC = DIT_CLK_HZ / 1_000_000 * DIT_TICK_US;
  localparam int unsigned DIT_QDEPTH = 16;
  localparam int unsigned DIT_NIN = 16;
  localparam logic [15:0] DIT_MS_MAX = 16'hEA5F; // 59999, last ms of a minute
  localparam logic [7:0] DIT_MIN_MAX = 8'h3B;
  localparam logic [7:0] DIT_HOUR_MAX = 8'h17;
  // register byte offsets
  localparam logic [7:0] DIT_OFS_CTRL = 8'h00;
  localparam logic [7:0] DIT_OFS_PAIR = 8'h04;
  localparam logic [7:0] DIT_OFS_FILT = 8'h08;
  localparam logic [7:0] DIT_OFS_STAT = 8'h0C;
  localparam logic [7:0] DIT_OFS_INP = 8'h10;
  localparam logic [1:0] DIT_PNT_WIN = 2'h1; // points at 0x40 + 4 * pin
  // field positions
  localparam int unsigned DIT_CTRL_INV = 8;
  localparam int unsigned DIT_CTRL_FUN = 16;
  // reset values
  localparam logic [7:0] DIT_RST_ADDR = 8'h01;
  localparam logic [7:0] DIT_RST_FUN = 8'hA0; // 160
  localparam logic [17:0] DIT_RST_FILT = 18'h0_0064; // 100 ms
  localparam logic [15:0] DIT_PAIR_OK = 16'h5555; // first pin odd-numbered
  localparam logic [15:0] DIT_EVEN_PIN = 16'hAAAA;
  localparam logic [7:0] DIT_BCAST = 8'hFF;
  // function codes
  localparam logic [3:0] DIT_FC_RST_CU = 4'h0;
  localparam logic [3:0] DIT_FC_UDATA = 4'h3;
  localparam logic [3:0] DIT_FC_RST_FCB = 4'h7;
  localparam logic [3:0] DIT_FC_CLASS1 = 4'hA;
  localparam logic [3:0] DIT_FC_CLASS2 = 4'hB;
  // type ids, causes and function types
  localparam logic [7:0] DIT_TI_DPI = 8'h01;
  localparam logic [7:0] DIT_TI_IDENT = 8'h05;
  localparam logic [7:0] DIT_TI_SYNC = 8'h06;
  localparam logic [7:0] DIT_TI_GI = 8'h07;
  localparam logic [7:0] DIT_TI_GI_END = 8'h08;
  localparam logic [7:0] DIT_COT_SPONT = 8'h01;
  localparam logic [7:0] DIT_COT_START = 8'h04;
  localparam logic [7:0] DIT_COT_SYNC = 8'h08;
  localparam logic [7:0] DIT_COT_GI = 8'h09;
  localparam logic [7:0] DIT_COT_GI_END = 8'h0A;
  localparam logic [7:0] DIT_FUN_GLOBAL = 8'hFF;
  localparam logic [7:0] DIT_INF_IDENT = 8'h01;
  // reply kinds
  localparam logic [1:0] DIT_RPL_ACK = 2'h0;
  localparam logic [1:0] DIT_RPL_NODATA = 2'h1;
  localparam logic [1:0] DIT_RPL_ASDU = 2'h2;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [15:0] ms;
  } dit_time_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [3:0] fc;
    logic [7:0] ti;
    logic [7:0] cot;
    dit_time_t tm;
  } dit_rx_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic acd;
    logic [7:0] addr;
    logic [7:0] ti;
    logic [7:0] cot;
    logic [7:0] fun;
    logic [7:0] inf;
    logic [1:0] dpi;
    dit_time_t tm;
  } dit_tx_t;

  typedef struct packed {
    logic [3:0] pin;
    logic [1:0] dpi;
    dit_time_t tm;
  } dit_evt_t;

  typedef enum logic [2:0] {
    DIT_ST_UNINIT = 3'b001,
    DIT_ST_READY = 3'b010,
    DIT_ST_GI = 3'b100
  } dit_state_t;
endpackage

// ---- hdl/dit_slave.sv ----
// controlled-station logic of a 16-input telecontrol slave
// assumes an outside codec handing decoded frames in and sending replies out
// How it works
// - reply only to a received request
// - acknowledge reset of unit or link
// - drop everything before initialising reset
// - class 2 replies flag pending spontaneous data
// - class 1 answered with time-tagged message
// - identification after reset, queued changes first
// - report change only after full filter time
// - change message: function type, pin number
// - time tag four bytes, no date
// - type 6 cause 8 loads clock
// - sync also accepted at link address 255
// - type 7 cause 9 starts interrogation, acked
// - interrogation ends with cause 10
// - interrogation sends time-tagged double points
// - inversion applied before filter
// - only odd-first neighbour pairs accepted
// - hidden even pin access gives error
// - sixteen states less one per pair
// - function type configurable, resets 160
// - link address configurable, resets 1
// - pair with both off reads 00
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module dit_slave #(
  parameter int unsigned TICK_CYC = dit_pkg::DIT_TICK_CYC,
  parameter int unsigned QDEPTH = dit_pkg::DIT_QDEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // digital inputs
  input wire logic [15:0] in_raw,
  // decoded frames from the link and replies to it
  input wire dit_pkg::dit_rx_t rx,
  output dit_pkg::dit_tx_t tx
);
  import dit_pkg::*;

  localparam int unsigned QW = $bits(dit_evt_t);
  localparam int unsigned TW = $clog2(TICK_CYC + 1);

  logic [7:0] link_addr_reg;
  logic [7:0] fun_reg;
  logic inv_reg;
  logic [15:0] pair_reg;
  logic [17:0] filt_reg;
  logic [TW-1:0] div_reg;
  logic tick;
  dit_time_t clk_reg;
  logic [15:0] stable;
  logic [15:0] chg;
  logic [15:0] hidden;
  logic [15:0] chg_m;
  logic [15:0] pend_reg;
  logic [15:0] pend_clr;
  logic [3:0] sel;
  logic sel_any;
  dit_evt_t evt_in;
  dit_evt_t evt_out;
  logic q_in_ready;
  logic q_valid;
  logic q_pop;
  logic [$clog2(QDEPTH):0] q_count;
  dit_state_t state_reg;
  logic id_pend_reg;
  logic [4:0] gi_idx_reg;
  logic for_me;
  logic bcast_sync;
  logic is_sync;
  logic is_gi;
  logic apb_wr;
  logic apb_rd;
  logic apb_err;

  // pins hidden behind a pair: even pin whose odd neighbour is paired
  assign hidden = {pair_reg[14:0], 1'b0} & DIT_EVEN_PIN;

  // double-point value of a reported pin
  function automatic logic [1:0] dpi_of(input logic [3:0] idx, input logic [15:0] st,
                                        input logic [15:0] pr);
    logic [3:0] nb;
    nb = idx | 4'h1;
    if (pr[idx]) begin
      dpi_of = {st[idx], st[nb]}; // both off gives 00
    end else begin
      dpi_of = st[idx] ? 2'b10 : 2'b01;
    end
  endfunction

  // first visible pin at or after a start index, 16 when none is left
  function automatic logic [4:0] next_vis(input logic [4:0] from, input logic [15:0] hid);
    next_vis = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (5'(i) >= from && !hid[i]) begin
        next_vis = 5'(i); // skips hidden pins
      end
    end
  endfunction

  // millisecond tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (div_reg == TW'(TICK_CYC - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = (div_reg == TW'(TICK_CYC - 1));

  // frame qualification
  assign is_sync = rx.fc == DIT_FC_UDATA && rx.ti == DIT_TI_SYNC && rx.cot == DIT_COT_SYNC;
  assign is_gi = rx.fc == DIT_FC_UDATA && rx.ti == DIT_TI_GI && rx.cot == DIT_COT_GI;
  assign for_me = rx.valid && rx.addr == link_addr_reg;
  assign bcast_sync = rx.valid && rx.addr == DIT_BCAST && is_sync;

  // time of day: ms, minute, hour, no date kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_reg <= '0;
    end else if ((for_me || bcast_sync) && is_sync && state_reg != DIT_ST_UNINIT) begin
      clk_reg <= rx.tm; // low bytes of the 7-byte structure
    end else if (tick) begin
      if (clk_reg.ms != DIT_MS_MAX) begin
        clk_reg.ms <= clk_reg.ms + 16'h0001;
      end else begin
        clk_reg.ms <= '0;
        if (clk_reg.min != DIT_MIN_MAX) begin
          clk_reg.min <= clk_reg.min + 8'h01;
        end else begin
          clk_reg.min <= '0;
          clk_reg.hour <= (clk_reg.hour == DIT_HOUR_MAX) ? 8'h00 : clk_reg.hour + 8'h01;
        end
      end
    end
  end

  // inversion ahead of the glitch filter
  dit_glitch_filter #(
    .N(DIT_NIN),
    .CW(18)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .limit(filt_reg),
    .din(in_raw ^ {16{inv_reg}}),
    .stable(stable),
    .chg(chg)
  );

  // change on a hidden pin is reported on its pair's odd pin
  assign chg_m = (chg & ~hidden) | ((chg & hidden) >> 1);

  // lowest pending change goes to the queue first
  always_comb begin
    sel = 4'h0;
    sel_any = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (pend_reg[i]) begin
        sel = 4'(i);
        sel_any = 1'b1;
      end
    end
  end
  assign pend_clr = (sel_any && q_in_ready) ? (16'h0001 << sel) : 16'h0000;

  // pending changes, a new change wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | chg_m;
    end
  end

  // change record: pin, state, four-byte time tag
  assign evt_in = '{pin: sel, dpi: dpi_of(sel, stable, pair_reg), tm: clk_reg};

  dit_evt_queue #(
    .W(QW),
    .DEPTH(QDEPTH)
  ) u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .push_valid(sel_any),
    .push_ready(q_in_ready),
    .push_data(evt_in),
    .pop_valid(q_valid),
    .pop_ready(q_pop),
    .pop_data(evt_out),
    .count(q_count)
  );

  // class 1 poll drains the queue ahead of identification
  assign q_pop = for_me && state_reg != DIT_ST_UNINIT && rx.fc == DIT_FC_CLASS1;

  // link state, identification and interrogation progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DIT_ST_UNINIT;
      id_pend_reg <= 1'b0;
      gi_idx_reg <= '0;
    end else if (for_me && (rx.fc == DIT_FC_RST_CU || rx.fc == DIT_FC_RST_FCB)) begin
      state_reg <= DIT_ST_READY;
      id_pend_reg <= 1'b1;
    end else if (for_me && state_reg != DIT_ST_UNINIT) begin
      case (state_reg)
        DIT_ST_READY: begin
          if (is_gi) begin
            state_reg <= DIT_ST_GI;
            gi_idx_reg <= next_vis(5'h00, hidden);
          end
        end
        DIT_ST_GI: begin
          if (is_gi) begin
            gi_idx_reg <= next_vis(5'h00, hidden);
          end else if (rx.fc == DIT_FC_CLASS2) begin
            if (gi_idx_reg[4]) begin
              state_reg <= DIT_ST_READY;
            end else begin
              gi_idx_reg <= next_vis(gi_idx_reg + 5'h01, hidden);
            end
          end
        end
        default: state_reg <= DIT_ST_UNINIT;
      endcase
      if (rx.fc == DIT_FC_CLASS1 && !q_valid) begin
        id_pend_reg <= 1'b0;
      end
    end
  end

  // one reply per addressed reset or later addressed request, nothing otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx <= '0;
    end else begin
      tx <= '0;
      tx.addr <= link_addr_reg;
      tx.fun <= fun_reg;
      tx.tm <= clk_reg;
      tx.acd <= (q_count > {{($bits(q_count)-1){1'b0}}, q_pop})
                || (id_pend_reg && !(q_pop && !q_valid));
      if (for_me && (rx.fc == DIT_FC_RST_CU || rx.fc == DIT_FC_RST_FCB)) begin
        tx.valid <= 1'b1;
        tx.kind <= DIT_RPL_ACK;
        tx.acd <= 1'b1;
      end else if (for_me && state_reg != DIT_ST_UNINIT) begin
        tx.valid <= 1'b1;
        tx.kind <= DIT_RPL_NODATA;
        if (rx.fc == DIT_FC_UDATA && (is_sync || is_gi)) begin
          tx.kind <= DIT_RPL_ACK;
        end else if (rx.fc == DIT_FC_CLASS1 && q_valid) begin
          tx.kind <= DIT_RPL_ASDU;
          tx.ti <= DIT_TI_DPI;
          tx.cot <= DIT_COT_SPONT;
          tx.inf <= {4'h0, evt_out.pin} + 8'h01;
          tx.dpi <= evt_out.dpi;
          tx.tm <= evt_out.tm;
        end else if (rx.fc == DIT_FC_CLASS1 && id_pend_reg) begin
          tx.kind <= DIT_RPL_ASDU;
          tx.ti <= DIT_TI_IDENT;
          tx.cot <= DIT_COT_START;
          tx.fun <= DIT_FUN_GLOBAL;
          tx.inf <= DIT_INF_IDENT;
        end else if (rx.fc == DIT_FC_CLASS2 && state_reg == DIT_ST_GI) begin
          tx.kind <= DIT_RPL_ASDU;
          if (gi_idx_reg[4]) begin
            tx.ti <= DIT_TI_GI_END;
            tx.cot <= DIT_COT_GI_END;
            tx.fun <= DIT_FUN_GLOBAL;
          end else begin
            tx.ti <= DIT_TI_DPI;
            tx.cot <= DIT_COT_GI;
            tx.inf <= {3'h0, gi_idx_reg} + 8'h01;
            tx.dpi <= dpi_of(gi_idx_reg[3:0], stable, pair_reg);
          end
        end
      end
    end
  end

  // apb decode, zero wait states
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  always_comb begin
    apb_err = 1'b0;
    if (paddr[7:6] == DIT_PNT_WIN) begin
      apb_err = pwrite || hidden[paddr[5:2]];
    end else if (paddr == DIT_OFS_PAIR) begin
      apb_err = pwrite && ((pwdata[15:0] & ~DIT_PAIR_OK) != 16'h0000);
    end else if (paddr == DIT_OFS_STAT || paddr == DIT_OFS_INP) begin
      apb_err = pwrite;
    end else if (paddr != DIT_OFS_CTRL && paddr != DIT_OFS_FILT) begin
      apb_err = 1'b1;
    end
  end
  assign pslverr = psel && penable && apb_err;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_addr_reg <= DIT_RST_ADDR;
      fun_reg <= DIT_RST_FUN;
      inv_reg <= 1'b0;
      pair_reg <= '0;
      filt_reg <= DIT_RST_FILT;
    end else if (apb_wr && !apb_err) begin
      case (paddr)
        DIT_OFS_CTRL: begin
          link_addr_reg <= pwdata[7:0];
          inv_reg <= pwdata[DIT_CTRL_INV];
          fun_reg <= pwdata[DIT_CTRL_FUN +: 8];
        end
        DIT_OFS_PAIR: pair_reg <= pwdata[15:0];
        DIT_OFS_FILT: filt_reg <= pwdata[17:0];
        default: filt_reg <= filt_reg;
      endcase
    end
  end

  // read data, registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (paddr[7:6] == DIT_PNT_WIN) begin
        prdata <= hidden[paddr[5:2]] ? 32'h0000_0000 : {30'h0, dpi_of(paddr[5:2], stable, pair_reg)};
      end else begin
        case (paddr)
          DIT_OFS_CTRL: prdata <= {8'h00, fun_reg, 7'h00, inv_reg, link_addr_reg};
          DIT_OFS_PAIR: prdata <= {16'h0000, pair_reg};
          DIT_OFS_FILT: prdata <= {14'h0000, filt_reg};
          DIT_OFS_STAT: prdata <= {8'h00, 8'(q_count), 8'(16 - $countones(pair_reg)),
                                   5'h00, state_reg};
          DIT_OFS_INP: prdata <= {16'h0000, stable};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule
